// ===== hdl/rx_recovery_consts.vh
// Constants for the asynchronous serial receive front end.
`ifndef RX_RECOVERY_CONSTS_VH
`define RX_RECOVERY_CONSTS_VH

// Register byte addresses.
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_DATA 8'h08
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_MASK 8'h10

// Control register fields.
`define CTRL_ENABLE 0
`define CTRL_DOUBLE 1
`define CTRL_PARITY 2
`define CTRL_LEN_LO 4
`define CTRL_LEN_HI 7
`define CTRL_RESET 32'h00000080

// Character length limits (data bits only).
`define LEN_MIN 4'h5
`define LEN_MAX 4'h9

// Status register fields.
`define STAT_UNREAD 0
`define STAT_FERR 1
`define STAT_BUSY 2

// Interrupt event bits.
`define IRQ_DONE 0
`define IRQ_FERR 1
`define IRQ_OVERRUN 2
`define IRQ_NOISE 3
`define IRQ_BITS 4

// Samples per bit and first centre sample for each speed.
`define SPB_NORMAL 5'h10
`define SPB_DOUBLE 5'h08
`define FIRST_NORMAL 5'h08
`define FIRST_DOUBLE 5'h04

`endif

// ===== hdl/usart_async_rx_recovery.v
// Asynchronous serial receiver: start detection, majority vote bit recovery, APB registers.
//
// Local design decisions: the placing of the registers and the APB slave port.

`include "rx_recovery_consts.vh"

module usart_async_rx_recovery
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sample_tick,
   input wire serial_in_line,
   output reg irq
);

   localparam ST_IDLE = 2'b00;
   localparam ST_START = 2'b01;
   localparam ST_BITS = 2'b10;
   localparam ST_HOLD = 2'b11;
   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   reg [31:0] ctrl;
   reg [`IRQ_BITS-1:0] irq_stat;
   reg [`IRQ_BITS-1:0] irq_mask;
   reg sync_a;
   reg sync_b;
   reg line_last;
   reg [1:0] state;
   reg [4:0] sample_cnt;
   reg [1:0] vote_ones;
   reg [3:0] bit_idx;
   reg [9:0] shift;
   reg [9:0] rx_data;
   reg stop_bit_error_flag;
   reg rx_unread_flag;
   reg [`IRQ_BITS-1:0] events;
   reg [3:0] len_clamped;
   reg [3:0] frame_bits;
   wire receiver_enable;
   wire double_speed_select;
   wire [4:0] spb;
   wire [4:0] first_vote;
   wire [4:0] next_sample;
   wire in_vote;
   wire last_vote;
   wire voted_bit;
   wire wr_en;
   wire rd_en;
   wire data_pop;
   reg [31:0] next_prdata;
   reg next_pslverr;
   assign receiver_enable = ctrl[`CTRL_ENABLE];
   assign double_speed_select = ctrl[`CTRL_DOUBLE];

   ////////////////////////////////////////////////////////////////////////////
   // Sampling geometry for the selected speed.
   // Samples per bit and the first of the three centre samples.
   assign spb = double_speed_select ? `SPB_DOUBLE : `SPB_NORMAL;
   assign first_vote = double_speed_select ? `FIRST_DOUBLE : `FIRST_NORMAL;
   assign next_sample = (sample_cnt == spb) ? 5'h01 : sample_cnt + 5'h01;
   assign in_vote = (sample_cnt >= first_vote) && (sample_cnt <= first_vote + 5'h02);
   assign last_vote = (sample_cnt == first_vote + 5'h02);
   // Two or three of the centre samples decide the bit value.
   assign voted_bit = (vote_ones == 2'b10) || ((vote_ones == 2'b01) && sync_b);
   // Data length clamped to the supported range, then the parity bit added.
   always @*
   begin
      len_clamped = ctrl[`CTRL_LEN_HI:`CTRL_LEN_LO];
      if (len_clamped < `LEN_MIN)
      begin
         len_clamped = `LEN_MIN;
      end
      else if (len_clamped > `LEN_MAX)
      begin
         len_clamped = `LEN_MAX;
      end
      frame_bits = len_clamped + {3'b000, ctrl[`CTRL_PARITY]};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchroniser.
   // Two flops; only the second one feeds the receive logic.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end
      else
      begin
         sync_a <= serial_in_line;
         sync_b <= sync_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock and data recovery state machine.
   // Advances on each oversample tick; events are one-cycle pulses.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         sample_cnt <= 5'h00;
         vote_ones <= 2'b00;
         bit_idx <= 4'h0;
         shift <= 10'h000;
         line_last <= 1'b1;
         events <= {`IRQ_BITS{1'b0}};
         rx_data <= 10'h000;
         stop_bit_error_flag <= 1'b0;
         rx_unread_flag <= 1'b0;
      end
      else
      begin
         events <= {`IRQ_BITS{1'b0}};
         if (data_pop)
         begin
            rx_unread_flag <= 1'b0;
            stop_bit_error_flag <= 1'b0;
         end
         if (!receiver_enable)
         begin
            // Abandon any frame and flush the holding buffer.
            state <= ST_IDLE;
            rx_unread_flag <= 1'b0;
            stop_bit_error_flag <= 1'b0;
            rx_data <= 10'h000;
            line_last <= 1'b1;
         end
         else if (sample_tick)
         begin
            case (state)
               ST_IDLE:
               begin
                  line_last <= sync_b;
                  if (line_last && !sync_b)
                  begin
                     // This tick took sample one, so the counter names the next sample.
                     state <= ST_START;
                     sample_cnt <= 5'h02;
                     vote_ones <= 2'b00;
                  end
               end
               ST_START:
               begin
                  sample_cnt <= next_sample;
                  if (in_vote && sync_b)
                  begin
                     vote_ones <= vote_ones + 2'b01;
                  end
                  if (last_vote)
                  begin
                     vote_ones <= 2'b00;
                     if (voted_bit)
                     begin
                        // Majority high: noise spike, look for a new edge.
                        state <= ST_IDLE;
                        line_last <= sync_b;
                        events[`IRQ_NOISE] <= 1'b1;
                     end
                     else
                     begin
                        // Bit timing now follows this start bit; stale bits of a longer frame are cleared.
                        state <= ST_BITS;
                        bit_idx <= 4'h0;
                        shift <= 10'h000;
                     end
                  end
               end
               ST_BITS:
               begin
                  sample_cnt <= next_sample;
                  if (in_vote && sync_b)
                  begin
                     vote_ones <= vote_ones + 2'b01;
                  end
                  if (last_vote)
                  begin
                     vote_ones <= 2'b00;
                     bit_idx <= bit_idx + 4'h1;
                     if (bit_idx < frame_bits)
                     begin
                        // Data and parity bits enter LSB first.
                        shift[bit_idx] <= voted_bit;
                     end
                     else
                     begin
                        // First stop bit ends the frame; later stops ignored.
                        line_last <= voted_bit;
                        state <= double_speed_select ? ST_HOLD : ST_IDLE;
                        events[`IRQ_DONE] <= 1'b1;
                        events[`IRQ_FERR] <= ~voted_bit;
                        if (rx_unread_flag && !data_pop)
                        begin
                           events[`IRQ_OVERRUN] <= 1'b1;
                        end
                        else
                        begin
                           // Error flag travels with its frame.
                           rx_data <= shift;
                           stop_bit_error_flag <= ~voted_bit;
                           rx_unread_flag <= 1'b1;
                        end
                     end
                  end
               end
               ST_HOLD:
               begin
                  // Double speed waits one more sample before rearming.
                  state <= ST_IDLE;
                  line_last <= line_last & sync_b;
               end
               default:
               begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB access decode.
   // Writes and reads take effect in the access phase with pready high.
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && pready && !pwrite;
   assign data_pop = rd_en && (paddr == `ADDR_DATA);
   // Read data and error, prepared during the setup cycle.
   always @*
   begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      case (paddr)
         `ADDR_CTRL:
         begin
            next_prdata = ctrl;
         end
         `ADDR_STATUS:
         begin
            next_prdata[`STAT_UNREAD] = rx_unread_flag;
            next_prdata[`STAT_FERR] = stop_bit_error_flag;
            next_prdata[`STAT_BUSY] = (state != ST_IDLE);
         end
         `ADDR_DATA:
         begin
            next_prdata[9:0] = rx_data;
         end
         `ADDR_IRQ_STAT:
         begin
            next_prdata[`IRQ_BITS-1:0] = irq_stat;
         end
         `ADDR_IRQ_MASK:
         begin
            next_prdata[`IRQ_BITS-1:0] = irq_mask;
         end
         default:
         begin
            next_pslverr = 1'b1;
         end
      endcase
   end
   // Answer one cycle after setup, so every access takes two cycles.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h00000000;
         pslverr <= psel && !penable && next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, interrupt status and mask registers.
   // Status bits are write-one-to-clear; a new event wins over the clear.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= `CTRL_RESET;
         irq_stat <= {`IRQ_BITS{1'b0}};
         irq_mask <= {`IRQ_BITS{1'b0}};
         irq <= 1'b0;
      end
      else
      begin
         if (wr_en && (paddr == `ADDR_CTRL))
         begin
            ctrl <= {24'h000000, pwdata[`CTRL_LEN_HI:`CTRL_LEN_LO], 1'b0, pwdata[`CTRL_PARITY:0]};
         end
         if (wr_en && (paddr == `ADDR_IRQ_MASK))
         begin
            irq_mask <= pwdata[`IRQ_BITS-1:0];
         end
         if (wr_en && (paddr == `ADDR_IRQ_STAT))
         begin
            irq_stat <= (irq_stat & ~pwdata[`IRQ_BITS-1:0]) | events;
         end
         else
         begin
            irq_stat <= irq_stat | events;
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

endmodule // usart_async_rx_recovery

// ===== verification/serial_tx_model.sv
// Behavioural remote transmitter that drives the serial line.
module serial_tx_model
(
   input wire pclk,
   input wire sample_tick,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line = 1'b1;
   // Sends n bits first bit first, each for spb ticks; the last bit stays on the line.
   task automatic frame(input logic [11:0] b, input int n, input int spb);
      for (int i = 0; i < n; i++)
      begin
         line <= b[i];
         repeat (spb) @(posedge pclk iff sample_tick);
      end
   endtask
endmodule // serial_tx_model

// ===== verification/tb_usart_async_rx_recovery.sv
// Self-checking bench for the serial receive front end.
`include "rx_recovery_consts.vh"
module tb_usart_async_rx_recovery;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, sample_tick, line, pready, pslverr, irq, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int tdiv = 0;
   usart_async_rx_recovery dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_tick(sample_tick), .serial_in_line(line), .irq(irq));
   serial_tx_model tx_u (.pclk(pclk), .sample_tick(sample_tick), .line(line));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 5 ns.
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Oversample tick every fourth cycle, and the hang limit.
   always @(posedge pclk)
   begin
      tdiv <= (tdiv + 1) % 4;
      sample_tick <= (tdiv == 3);
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_count++;
         conclude();
      end
   end
   task automatic conclude();
      if (err_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
      n_compared++;
      if (seen !== x)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, seen);
      end
   endtask
   // One bus transfer; the request holds until the answer edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h00000000);
      chk(nm, q, x);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd("ctrl", `ADDR_CTRL, `CTRL_RESET);
      apb(1'b1, `ADDR_STATUS, 32'hFFFFFFFF);
      rd("status", `ADDR_STATUS, 32'h00000000);
      apb(1'b0, 8'h20, 32'h00000000);
      chk("unmapped", {31'h0, e}, 32'h00000001);
      apb(1'b1, `ADDR_IRQ_MASK, 32'h00000000);
      rd("mask off", `ADDR_IRQ_MASK, 32'h00000000);
      apb(1'b1, `ADDR_IRQ_MASK, 32'h0000000F);
      rd("mask", `ADDR_IRQ_MASK, 32'h0000000F);
   endtask
   // Receives one whole frame and checks flags, data and interrupt; the first stop bit follows start, data and parity.
   task automatic t_rx(input logic [31:0] c, input logic [11:0] b, input int n, input int spb, input logic [31:0] x);
      int s = 1 + c[`CTRL_LEN_HI:`CTRL_LEN_LO] + c[`CTRL_PARITY];
      apb(1'b1, `ADDR_CTRL, c);
      tx_u.frame(b, n, spb);
      rd("full", `ADDR_STATUS, {30'h0, ~b[s], 1'b1});
      rd("events", `ADDR_IRQ_STAT, {30'h0, ~b[s], 1'b1});
      chk("irq", {31'h0, irq}, 32'h00000001);
      rd("data", `ADDR_DATA, x);
      rd("empty", `ADDR_STATUS, 32'h00000000);
      apb(1'b1, `ADDR_IRQ_STAT, 32'h0000000F);
   endtask
   // A low pulse of k samples is noise; one of k plus one starts a frame.
   // Pulses begin on a tick edge so that the receiver sees exactly that many low samples.
   task automatic t_edge(input logic [31:0] c, input int k, input int spb);
      apb(1'b1, `ADDR_CTRL, c);
      @(posedge pclk iff sample_tick);
      tx_u.frame(12'h000, 1, k);
      tx_u.frame(12'h001, 1, spb);
      rd("noise", `ADDR_IRQ_STAT, 32'h00000008);
      rd("idle", `ADDR_STATUS, 32'h00000000);
      apb(1'b1, `ADDR_IRQ_STAT, 32'h0000000F);
      @(posedge pclk iff sample_tick);
      tx_u.frame(12'h000, 1, k + 1);
      tx_u.frame(12'h001, 1, 10 * spb);
      rd("edge data", `ADDR_DATA, 32'h000000FF);
      apb(1'b1, `ADDR_IRQ_STAT, 32'h0000000F);
   endtask
   // Next start right after the stop vote; or a disable in mid-frame.
   task automatic t_next(input logic dis);
      apb(1'b1, `ADDR_CTRL, 32'h00000081);
      @(posedge pclk iff sample_tick);
      tx_u.frame(12'hFA5 << 1, 9, 16);
      tx_u.frame(12'h001, 1, 10);
      fork
         tx_u.frame({3'b111, 8'h5A, 1'b0}, 10, 16);
         begin
            repeat (40) @(posedge pclk iff sample_tick);
            apb(1'b1, `ADDR_CTRL, dis ? 32'h00000080 : 32'h00000081);
            rd("first", `ADDR_DATA, dis ? 32'h00000000 : 32'h000000A5);
         end
      join
      if (dis)
         rd("flushed", `ADDR_STATUS, 32'h00000000);
      else
         rd("second", `ADDR_DATA, 32'h0000005A);
      apb(1'b1, `ADDR_IRQ_STAT, 32'h0000000F);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_rx(32'h00000081, {2'b11, 1'b1, 8'hA5, 1'b0}, 10, 16, 32'h000000A5);
      t_rx(32'h00000053, {5'h1F, 1'b1, 5'h15, 1'b0}, 7, 8, 32'h00000015);
      t_rx(32'h00000095, {1'b1, 10'h2A5, 1'b0}, 12, 16, 32'h000002A5);
      t_rx(32'h00000081, {1'b1, 1'b0, 8'h3C, 1'b0}, 11, 16, 32'h0000003C);
      t_edge(32'h00000081, 8, 16);
      t_edge(32'h00000083, 4, 8);
      t_next(1'b0);
      t_next(1'b1);
      conclude();
   end
endmodule // tb_usart_async_rx_recovery

// ===== verification/usart_rx_checker.sv
// Checker for the bus and interrupt ports of the serial receive front end.
`include "rx_recovery_consts.vh"
module usart_rx_checker
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire sample_tick,
   input wire serial_in_line,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Decoded phases of a bus transfer.
   wire setup = psel && !penable;
   wire done_wr = psel && penable && pready && pwrite;
   ////////////////////////////////////////////////////////////////////////////////
   property p_setup_ready; setup |=> pready; endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");
   property p_ready_single; pready |=> !pready; endproperty
   a_ready_single: assert property (p_ready_single) else $error("answer longer than one cycle");
   property p_ready_cause; pready |-> $past(setup); endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("answer without setup");
   property p_err_in_answer; pslverr |-> pready; endproperty
   a_err_in_answer: assert property (p_err_in_answer) else $error("error outside answer");
   property p_data_quiet; !pready |-> prdata == 32'h00000000; endproperty
   a_data_quiet: assert property (p_data_quiet) else $error("read data outside answer");
   property p_unmapped; setup && paddr > `ADDR_IRQ_MASK |=> pslverr && prdata == 32'h00000000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_mapped; setup && paddr[1:0] == 2'b00 && paddr <= `ADDR_IRQ_MASK |=> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_mask_off; done_wr && paddr == `ADDR_IRQ_MASK && pwdata[3:0] == 4'h0 |-> ##2 !irq [*2]; endproperty
   a_mask_off: assert property (p_mask_off) else $error("interrupt despite full mask");
   // Main scenarios seen at the ports.
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_dbl: cover property (done_wr && paddr == `ADDR_CTRL && pwdata[1]);
endmodule // usart_rx_checker
bind usart_async_rx_recovery usart_rx_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_tick(sample_tick), .serial_in_line(serial_in_line), .irq(irq));
